/* hw/dor_top.sv */
// Digital output stage with polarity, manual force, routing and status LEDs
`timescale 1ns/1ps
`include "dor_defs.svh"
module dor_top #(
   parameter int NUM_OUT = 2,
   parameter int SWPWM_HALF = `DOR_SWPWM_HALF_CYC,
   parameter int OUT_HALF = `DOR_OUT_HALF_CYC
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   output logic [31:0] reg_rdata_o,
   input wire logic [31:0] enc_count_i,
   input wire logic [31:0] pos_value_i,
   input wire logic pwm_gen_i,
   output logic brake_o,
   output logic [NUM_OUT-1:0] out_o,
   output logic [NUM_OUT-1:0] out_oe_o,
   output logic swpwm_o,
   output logic led_green_o,
   output logic led_red_o
);
   dor_pkg::dor_req_t req;
   logic [31:0] control_word;
   logic [31:0] polarity;
   logic [31:0] man_en;
   logic [31:0] man_val;
   logic route_en;
   logic [1:0] led_ctl;
   logic [15:0] route_cfg [0:NUM_OUT];
   logic [31:0] applied;
   logic [31:0] enc_prev;
   logic [31:0] pos_prev;
   logic [NUM_OUT:0] route_sig;
   logic [NUM_OUT:0] pin_level;
   logic [31:0] next_rdata;
   logic [31:0] norm_val;
   logic [31:0] next_applied;
   assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};
   // A step of exactly one in either direction counts as one increment
   wire logic [31:0] enc_diff = enc_count_i - enc_prev;
   wire logic [31:0] pos_diff = pos_value_i - pos_prev;
   wire logic enc_step = enc_diff == 32'h0000_0001 || enc_diff == 32'hffff_ffff;
   wire logic pos_step = pos_diff == 32'h0000_0001 || pos_diff == 32'hffff_ffff;
   wire logic wr_ctrl = req.wr && req.addr == `DOR_REG_CONTROL;
   wire logic wr_pol = req.wr && req.addr == `DOR_REG_POLARITY;
   wire logic wr_men = req.wr && req.addr == `DOR_REG_MAN_EN;
   wire logic wr_mval = req.wr && req.addr == `DOR_REG_MAN_VAL;
   wire logic wr_ren = req.wr && req.addr == `DOR_REG_ROUTE_EN;
   wire logic wr_led = req.wr && req.addr == `DOR_REG_LED;
   wire logic [7:0] route_idx = 8'(req.addr - `DOR_REG_ROUTE_BASE);
   // Normal path: control bit, manual override, then polarity
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         norm_val[i] = man_en[i] ? man_val[i] : control_word[i];
         norm_val[i] = norm_val[i] ^ polarity[i];
      end
   end
   genvar g;
   generate
      for (g = 0; g <= NUM_OUT; g++) begin : gen_ch
         // Entry 0 feeds the soft PWM pin, entry g the output g-1
         dor_route_ch #(
            .HALF_CYC(g == 0 ? SWPWM_HALF : OUT_HALF)
         ) u_ch (
            .clock_i(clock_i),
            .rst_i(rst_i),
            .cfg_i(route_cfg[g]),
            .ctrl_i(control_word),
            .enc_step_i(enc_step),
            .pos_step_i(pos_step),
            .pwm_i(pwm_gen_i),
            .route_o(route_sig[g])
         );
         always_ff @(posedge clock_i or posedge rst_i) begin
            if (rst_i)
               route_cfg[g] <= `DOR_ROUTE_OFF;
            else if (req.wr && route_idx == 8'(g))
               route_cfg[g] <= req.wdata[15:0];
         end
         // An all-ones entry leaves the output on its normal path and holds the soft PWM pin low
         wire logic routed = route_en && route_cfg[g] != `DOR_ROUTE_OFF;
         if (g == 0) begin : gen_sw
            assign pin_level[g] = routed ? route_sig[g] : 1'b0;
         end else begin : gen_out
            assign pin_level[g] = routed ? route_sig[g] : norm_val[`DOR_OUT_BIT0 + g - 1];
         end
      end
   endgenerate
   always_comb begin
      next_applied = norm_val;
      next_applied[`DOR_BRAKE_BIT] = norm_val[`DOR_BRAKE_BIT];
      for (int i = 1; i <= NUM_OUT; i++)
         next_applied[`DOR_OUT_BIT0 + i - 1] = pin_level[i];
   end
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         control_word <= 32'h0000_0000;
         polarity <= 32'h0000_0000;
         man_en <= 32'h0000_0000;
         man_val <= 32'h0000_0000;
         route_en <= 1'b0;
         led_ctl <= 2'b00;
      end else begin
         if (wr_ctrl)
            control_word <= req.wdata;
         if (wr_pol)
            polarity <= req.wdata;
         if (wr_men)
            man_en <= req.wdata;
         if (wr_mval)
            man_val <= req.wdata;
         if (wr_ren)
            route_en <= req.wdata == 32'h0000_0001;
         if (wr_led)
            led_ctl <= req.wdata[1:0];
      end
   end
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         enc_prev <= 32'h0000_0000;
         pos_prev <= 32'h0000_0000;
      end else begin
         enc_prev <= enc_count_i;
         pos_prev <= pos_value_i;
      end
   end
   // Spurious first step after reset is possible if a count starts at one or all ones
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         applied <= 32'h0000_0000;
         brake_o <= 1'b0;
         out_o <= '0;
         out_oe_o <= '0;
         swpwm_o <= 1'b0;
         led_green_o <= 1'b0;
         led_red_o <= 1'b0;
      end else begin
         applied <= next_applied;
         brake_o <= next_applied[`DOR_BRAKE_BIT];
         out_o <= pin_level[NUM_OUT:1];
         // Open drain: sink current while the output level is low
         out_oe_o <= ~pin_level[NUM_OUT:1];
         swpwm_o <= pin_level[0];
         led_green_o <= led_ctl[`DOR_LED_GREEN_BIT];
         led_red_o <= led_ctl[`DOR_LED_RED_BIT];
      end
   end
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (req.addr)
         `DOR_REG_CONTROL: next_rdata = control_word;
         `DOR_REG_POLARITY: next_rdata = polarity;
         `DOR_REG_MAN_EN: next_rdata = man_en;
         `DOR_REG_MAN_VAL: next_rdata = man_val;
         `DOR_REG_APPLIED: next_rdata = applied;
         `DOR_REG_ROUTE_EN: next_rdata = {31'h0000_0000, route_en};
         `DOR_REG_LED: next_rdata = {30'h0000_0000, led_ctl};
         default: begin
            for (int i = 0; i <= NUM_OUT; i++)
               if (route_idx == 8'(i))
                  next_rdata = {16'h0000, route_cfg[i]};
         end
      endcase
   end
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i)
         reg_rdata_o <= 32'h0000_0000;
      else if (req.rd)
         reg_rdata_o <= next_rdata;
   end
endmodule

/* common/dor_defs.svh */
// Register offsets, field positions, reset values and timing counts of the output routing block
`ifndef DOR_DEFS_SVH
`define DOR_DEFS_SVH
`define DOR_REG_CONTROL 8'h00
`define DOR_REG_UNUSED 8'h01
`define DOR_REG_POLARITY 8'h02
`define DOR_REG_MAN_EN 8'h03
`define DOR_REG_MAN_VAL 8'h04
`define DOR_REG_APPLIED 8'h05
`define DOR_REG_ROUTE_EN 8'h08
`define DOR_REG_LED 8'h09
`define DOR_REG_ROUTE_BASE 8'h10
`define DOR_OUT_BIT0 16
`define DOR_BRAKE_BIT 0
`define DOR_LED_GREEN_BIT 0
`define DOR_LED_RED_BIT 1
`define DOR_INV_BIT 7
`define DOR_ROUTE_OFF 16'hffff
`define DOR_SRC_ONE 8'h00
`define DOR_SRC_ZERO 8'h01
`define DOR_SRC_ENC_FIRST 8'h02
`define DOR_SRC_ENC_LAST 8'h08
`define DOR_SRC_POS_FIRST 8'h09
`define DOR_SRC_POS_LAST 8'h0f
`define DOR_SRC_PWM 8'h10
`define DOR_SRC_PWM_INV 8'h11
`define DOR_CLK_HZ 25000000
`define DOR_SWPWM_MAX_HZ 2000
`define DOR_OUT_MAX_HZ 500
`define DOR_SWPWM_HALF_CYC (`DOR_CLK_HZ / (2 * `DOR_SWPWM_MAX_HZ))
`define DOR_OUT_HALF_CYC (`DOR_CLK_HZ / (2 * `DOR_OUT_MAX_HZ))
`endif

/* common/dor_pkg.sv */
// Types shared by the output routing block
package dor_pkg;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } dor_req_t;
   typedef enum logic [2:0] {
      DOR_ST_LOW = 3'b001,
      DOR_ST_HIGH = 3'b010,
      DOR_ST_HOLD = 3'b100
   } dor_pulse_st_t;
endpackage

/* hw/dor_route_ch.sv */
// One routing channel: source select, divider, gating and rate limit
`timescale 1ns/1ps
`include "dor_defs.svh"
module dor_route_ch #(
   parameter int HALF_CYC = 25000
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [15:0] cfg_i,
   input wire logic [31:0] ctrl_i,
   input wire logic enc_step_i,
   input wire logic pos_step_i,
   input wire logic pwm_i,
   output logic route_o
);
   localparam int CW = $clog2(HALF_CYC + 1);
   dor_pkg::dor_pulse_st_t st;
   dor_pkg::dor_pulse_st_t next_st;
   logic [6:0] div_cnt;
   logic [CW-1:0] hold_cnt;
   logic [3:0] pend;
   logic route_q;
   wire logic [7:0] src = cfg_i[15:8];
   wire logic [4:0] sel = cfg_i[4:0];
   wire logic is_enc = src >= `DOR_SRC_ENC_FIRST && src <= `DOR_SRC_ENC_LAST;
   wire logic is_pos = src >= `DOR_SRC_POS_FIRST && src <= `DOR_SRC_POS_LAST;
   wire logic [2:0] div_log = is_enc ? 3'(src - `DOR_SRC_ENC_FIRST) : 3'(src - `DOR_SRC_POS_FIRST);
   wire logic step = (is_enc & enc_step_i) | (is_pos & pos_step_i);
   wire logic [6:0] div_mask = 7'h7f >> (3'd7 - div_log);
   wire logic div_hit = step && ((div_cnt & div_mask) == div_mask);
   // Pulses arriving faster than the output can show them are queued, fifteen at most
   wire logic pulse_go = (st == dor_pkg::DOR_ST_LOW) && (pend != 4'h0) && (hold_cnt == '0);
   wire logic gate = ctrl_i[sel] ^ cfg_i[`DOR_INV_BIT];
   always_comb begin
      next_st = st;
      case (st)
         dor_pkg::DOR_ST_LOW: if (pulse_go) next_st = dor_pkg::DOR_ST_HIGH;
         dor_pkg::DOR_ST_HIGH: if (hold_cnt == '0) next_st = dor_pkg::DOR_ST_HOLD;
         dor_pkg::DOR_ST_HOLD: if (hold_cnt == '0) next_st = dor_pkg::DOR_ST_LOW;
         default: next_st = dor_pkg::DOR_ST_LOW;
      endcase
   end
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         st <= dor_pkg::DOR_ST_LOW;
         div_cnt <= 7'h00;
         hold_cnt <= '0;
         pend <= 4'h0;
      end else begin
         st <= next_st;
         if (step)
            div_cnt <= div_cnt + 7'h01;
         // Width limit keeps pulses within the output's frequency ceiling
         if (next_st != st)
            hold_cnt <= CW'(HALF_CYC - 1);
         else if (hold_cnt != '0)
            hold_cnt <= hold_cnt - CW'(1);
         if (div_hit && !pulse_go && pend != 4'hf)
            pend <= pend + 4'h1;
         else if (pulse_go && !div_hit)
            pend <= pend - 4'h1;
      end
   end
   always_comb begin
      case (src)
         `DOR_SRC_ONE: route_q = 1'b1;
         `DOR_SRC_ZERO: route_q = 1'b0;
         `DOR_SRC_PWM: route_q = pwm_i;
         `DOR_SRC_PWM_INV: route_q = ~pwm_i;
         default: route_q = (is_enc | is_pos) && st == dor_pkg::DOR_ST_HIGH;
      endcase
   end
   assign route_o = gate & route_q;
endmodule

/* dv/dor_load_model.sv */
// External loads on the open-drain output pins
`timescale 1ns/1ps
module dor_load_model (
   input wire logic [1:0] oe_i,
   output logic [1:0] pin_o
);
   // Pull-up resistor lifts the pin whenever the sink is off
   assign pin_o = ~oe_i;
endmodule

/* dv/dor_top_checker.sv */
// Port checker for the output routing block
`timescale 1ns/1ps
module dor_top_checker #(
   parameter int NUM_OUT = 2
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic brake_o,
   input wire logic [NUM_OUT-1:0] out_o,
   input wire logic [NUM_OUT-1:0] out_oe_o,
   input wire logic swpwm_o,
   input wire logic led_green_o,
   input wire logic led_red_o
);
   default clocking @(posedge clock_i); endclocking
   logic [31:0] sh [0:31];
   logic [3:0] quiet;
   // Shadow copy of written entries; checks wait until writes have settled
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < 32; i++) sh[i] <= (i >= 16) ? 32'h0000_ffff : 32'h0000_0000;
         quiet <= 4'h0;
      end else begin
         if (reg_wr_i && reg_addr_i < 8'h20) sh[reg_addr_i[4:0]] <= reg_wdata_i;
         quiet <= reg_wr_i ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
      end
   end
   wire ok = quiet == 4'hf;
   wire ren = sh[8] == 32'h0000_0001;
   wire [31:0] nrm = (~sh[3] & (sh[0] ^ sh[2])) | (sh[3] & sh[4]);
   wire [15:0] c1 = sh[17][15:0];
   wire g1 = sh[0][c1[4:0]] ^ c1[7];
   sequence s_no_read;
      !reg_rd_i ##1 !reg_rd_i;
   endsequence
   a_reset_clean: assert property (rst_i |-> out_o == 0 && !brake_o && !swpwm_o && !led_green_o && !led_red_o)
      else $error("outputs not cleared in reset");
   a_oe_inverse: assert property (disable iff (rst_i) !$past(rst_i, 2) |-> out_oe_o == ~out_o)
      else $error("sink enable not inverse of level");
   a_out_normal: assert property (disable iff (rst_i) ok && !ren |-> out_o == nrm[16 +: NUM_OUT])
      else $error("output level wrong");
   a_brake_level: assert property (disable iff (rst_i) ok && !ren |-> brake_o == nrm[0])
      else $error("brake level wrong");
   a_led_map: assert property (disable iff (rst_i) ok |-> {led_red_o, led_green_o} == sh[9][1:0])
      else $error("led enables wrong");
   a_swpwm_idle: assert property (disable iff (rst_i) ok && (!ren || sh[16][15:0] == 16'hffff) |-> !swpwm_o)
      else $error("soft pwm pin active while unrouted");
   a_const_route: assert property (disable iff (rst_i) ok && ren && c1[15:9] == 0 |-> out_o[0] == (g1 & ~c1[8]))
      else $error("constant routed level wrong");
   a_route_off: assert property (disable iff (rst_i) ok && ren && c1 == 16'hffff |-> out_o[0] == nrm[16])
      else $error("disabled route left normal path");
   a_rdata_hold: assert property (disable iff (rst_i) s_no_read |=> $stable(reg_rdata_o))
      else $error("read data changed without read");
endmodule
bind dor_top dor_top_checker #(.NUM_OUT(NUM_OUT)) u_chk (.clock_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
   .reg_wdata_i, .reg_rdata_o, .brake_o, .out_o, .out_oe_o, .swpwm_o, .led_green_o, .led_red_o);

/* dv/dor_top_bench.sv */
// Self-checking bench for the output routing block
`timescale 1ns/1ps
module dor_top_bench;
   logic clock_i = 0, rst_i = 0, reg_wr_i = 0, reg_rd_i = 0, pwm_gen_i = 1;
   logic [7:0] reg_addr_i = 0;
   logic [31:0] reg_wdata_i = 0, enc_count_i = 0, pos_value_i = 0, reg_rdata_o;
   logic brake_o, swpwm_o, led_green_o, led_red_o;
   logic [1:0] out_o, out_oe_o, pin;
   logic [15:0] cf [6] = '{16'h0005, 16'h0085, 16'h0105, 16'h0006, 16'h0086, 16'hffff};
   logic [5:0] ex = 6'b010001;
   logic [7:0] src [6] = '{8'h02, 8'h03, 8'h04, 8'h09, 8'h0a, 8'h0c};
   int np [6] = '{8, 4, 2, 8, 4, 1};
   int err_count = 0, checks = 0, cyc = 0, edges = 0;
   always #20 clock_i = ~clock_i;
   dor_top #(.SWPWM_HALF(4), .OUT_HALF(4)) DUT (.*);
   dor_load_model LOAD (.oe_i(out_oe_o), .pin_o(pin));
   always @(posedge swpwm_o) edges++;
   // Cycle ceiling well above the expected run of about 1100 cycles
   always @(posedge clock_i) if (++cyc > 8000) begin
      err_count++;
      finish_test();
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge clock_i);
      reg_wr_i = 1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(negedge clock_i);
      reg_wr_i = 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(negedge clock_i);
      reg_rd_i = 1;
      reg_addr_i = a;
      @(negedge clock_i);
      reg_rd_i = 0;
      repeat (2) @(negedge clock_i);
      chk("read data", exp, reg_rdata_o);
   endtask
   // Settling wait, longer than the checker's quiet window
   task automatic wt();
      repeat (16) @(negedge clock_i);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      // Raised after time zero so the asynchronous reset sees a real edge
      #1 rst_i = 1;
      repeat (12) @(negedge clock_i);
      rst_i = 0;
      chk("pins", 0, {brake_o, out_o, swpwm_o, led_green_o, led_red_o});
      rd(8'h05, 32'h0000_0000);
      $display("test reset done");
      wr(8'h00, 32'h0003_0001);
      wt();
      chk("outputs", 32'h0000_0007, {brake_o, out_o});
      chk("pins", 32'h0000_0003, pin);
      rd(8'h05, 32'h0003_0001);
      wr(8'h02, 32'h0001_0000);
      wr(8'h03, 32'h0002_0001);
      wr(8'h04, 32'h0000_0001);
      wt();
      chk("forced", 32'h0000_0004, {brake_o, out_o});
      rd(8'h05, 32'h0000_0001);
      wr(8'h05, 32'hffff_ffff);
      rd(8'h05, 32'h0000_0001);
      rd(8'h3f, 32'h0000_0000);
      $display("test control done");
      for (int i = 0; i < 4; i++) begin
         wr(8'h09, 32'(i));
         wt();
         chk("leds", 32'(i), {led_red_o, led_green_o});
      end
      $display("test leds done");
      wr(8'h08, 32'h0000_0001);
      wr(8'h00, 32'h0001_0021);
      for (int i = 0; i < 6; i++) begin
         wr(8'h11, {16'h0000, cf[i]});
         wt();
         chk("routed", {31'h0, ex[i]}, out_o[0]);
      end
      for (int j = 0; j < 2; j++) begin
         wr(8'h12, {16'h0000, 8'h10 + 8'(j), 8'h00});
         wt();
         chk("pwm route", 32'(1 - j), out_o[1]);
         pwm_gen_i = 0;
         wt();
         chk("pwm route", 32'(j), out_o[1]);
         pwm_gen_i = 1;
      end
      $display("test routing done");
      for (int i = 0; i < 6; i++) begin
         wr(8'h10, {16'h0000, src[i], 8'h00});
         wt();
         edges = 0;
         repeat (8) begin
            if (i < 3) enc_count_i++;
            else pos_value_i++;
            repeat (12) @(negedge clock_i);
         end
         wt();
         chk("pulses", 32'(np[i]), 32'(edges));
      end
      wr(8'h10, 32'h0000_ffff);
      wt();
      chk("soft pwm idle", 0, swpwm_o);
      $display("test pulses done");
      rst_i = 1;
      repeat (2) @(negedge clock_i);
      rst_i = 0;
      chk("pins", 0, {brake_o, out_o, swpwm_o, led_green_o, led_red_o});
      rd(8'h08, 32'h0000_0000);
      rd(8'h10, 32'h0000_ffff);
      $display("test second reset done");
      finish_test();
   end
endmodule
